/* File: rtl/rcs_defines.svh */
// Constants of the reference clock selector: register offsets, fields, counts.
// Assumes inclusion by bare name from the design modules, the checker and the bench.
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH
// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define RCS_OFF_CTRL 12'h000
`define RCS_OFF_STAT 12'h004
`define RCS_OFF_TMO 12'h008
`define RCS_OFF_FREQ 12'h00c
// ****************************************************************
// Control field positions
// ****************************************************************
`define RCS_CTL_ON 0
`define RCS_CTL_FREE 1
`define RCS_CTL_PREF 2
`define RCS_CTL_AUX 3
`define RCS_CTL_RST 4'h0
// ****************************************************************
// Timing constants
// ****************************************************************
`define RCS_PCLK_HZ 20000000
`define RCS_SYS_HZ 10240000
`define RCS_LINE_HZ 2000000
`define RCS_TMO_RST 24'h004e20
`define RCS_LOSS_CYC 8'h40
`define RCS_WIN_CYC 16'h2710
`define RCS_LOCK_TOL 16'h0004
`define RCS_SPEC_LO 16'h03b6
`define RCS_SPEC_HI 16'h041a
`define RCS_FLASH_BIT 21
`define RCS_FREQ_MID 16'h8000
`define RCS_FRAME_BITS 8'hff
`define RCS_MF_FRAMES 4'hf
`endif

/* File: rtl/rcs_pkg.sv */
// Types shared by the reference clock selector modules.
// Assumes the defines header is on the include path.
package rcs_pkg;
  // Controller state, one-hot
  typedef enum logic [3:0] {
    RCS_ST_FREE = 4'h1,
    RCS_ST_TRACK = 4'h2,
    RCS_ST_LOCK = 4'h4,
    RCS_ST_HOLD = 4'h8
  } rcs_state_t;
endpackage

/* File: rtl/rcs_ref_mon.sv */
// Reference monitor: synchronises one reference, counts its edges per window,
// and flags it out of specification when it stops or strays too far.
// Assumes the reference is asynchronous to pclk and well below pclk/2.
`timescale 1ns/10ps
`include "rcs_defines.svh"
module rcs_ref_mon (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Reference pin
  input wire logic ref_in,
  // Window tick from the top, and results
  input wire logic win_tick,
  output logic [15:0] edge_cnt,
  output logic in_spec,
  output logic ref_edge
);
  logic [2:0] sync_ff; // Three-stage synchroniser
  logic [2:0] nxt_sync;
  logic lvl_ff; // Accepted level
  logic nxt_lvl;
  logic [15:0] cnt_ff; // Edges this window
  logic [15:0] nxt_cnt;
  logic [15:0] last_ff; // Edges last window
  logic [15:0] nxt_last;
  logic [7:0] idle_ff; // Cycles since last edge
  logic [7:0] nxt_idle;
  logic spec_ff;
  logic nxt_spec;
  logic edge_ff;
  logic nxt_edge;
  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Stage one feeds only stage two; stages two and three must agree
  always_comb begin
    nxt_sync = {sync_ff[1:0], ref_in};
    nxt_lvl = lvl_ff;
    nxt_edge = 1'b0;
    if (sync_ff[1] == sync_ff[2]) begin
      nxt_lvl = sync_ff[2];
      nxt_edge = sync_ff[2] & ~lvl_ff;
    end
    nxt_cnt = cnt_ff;
    nxt_last = last_ff;
    nxt_idle = idle_ff;
    nxt_spec = spec_ff;
    if (nxt_edge) begin
      nxt_idle = 8'h00;
      nxt_cnt = cnt_ff + 16'h0001;
    end else if (idle_ff != `RCS_LOSS_CYC) begin
      nxt_idle = idle_ff + 8'h01;
    end
    // Lost edges make it unusable at once; window verdict otherwise
    if (idle_ff == `RCS_LOSS_CYC) begin
      nxt_spec = 1'b0;
    end else if (win_tick) begin
      nxt_spec = (cnt_ff >= `RCS_SPEC_LO) && (cnt_ff <= `RCS_SPEC_HI);
    end
    if (win_tick) begin
      nxt_last = cnt_ff;
      nxt_cnt = 16'h0000;
    end
  end
  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff <= 3'h0;
      lvl_ff <= 1'b0;
      cnt_ff <= 16'h0000;
      last_ff <= 16'h0000;
      idle_ff <= 8'h00;
      spec_ff <= 1'b0;
      edge_ff <= 1'b0;
    end else begin
      sync_ff <= nxt_sync;
      lvl_ff <= nxt_lvl;
      cnt_ff <= nxt_cnt;
      last_ff <= nxt_last;
      idle_ff <= nxt_idle;
      spec_ff <= nxt_spec;
      edge_ff <= nxt_edge;
    end
  end
  assign edge_cnt = last_ff;
  assign in_spec = spec_ff;
  assign ref_edge = edge_ff;
endmodule // rcs_ref_mon

/* File: rtl/rcs_frame_cnt.sv */
// Frame counter: counts line clock edges of the active reference into bit,
// frame and multiframe positions.
// Assumes edges arrive as one-cycle pulses on pclk.
`timescale 1ns/10ps
`include "rcs_defines.svh"
module rcs_frame_cnt (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line clock edge
  input wire logic bit_edge,
  // Positions
  output logic [7:0] bit_pos,
  output logic [3:0] frame_pos,
  output logic mf_start
);
  logic [7:0] bit_ff;
  logic [7:0] nxt_bit;
  logic [3:0] frm_ff;
  logic [3:0] nxt_frm;
  logic mf_ff;
  logic nxt_mf;
  // ****************************************************************
  // Counting
  // ****************************************************************
  // Frame and multiframe wrap follow the recovered line clock
  always_comb begin
    nxt_bit = bit_ff;
    nxt_frm = frm_ff;
    nxt_mf = 1'b0;
    if (bit_edge) begin
      nxt_bit = bit_ff + 8'h01;
      if (bit_ff == `RCS_FRAME_BITS) begin
        nxt_frm = frm_ff + 4'h1;
        nxt_mf = (frm_ff == `RCS_MF_FRAMES);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_ff <= 8'h00;
      frm_ff <= 4'h0;
      mf_ff <= 1'b0;
    end else begin
      bit_ff <= nxt_bit;
      frm_ff <= nxt_frm;
      mf_ff <= nxt_mf;
    end
  end
  assign bit_pos = bit_ff;
  assign frame_pos = frm_ff;
  assign mf_start = mf_ff;
endmodule // rcs_frame_cnt

/* File: rtl/rcs_top.sv */
// Reference clock selector: chooses a primary or secondary reference, steers a
// numerically controlled system clock toward it, and reports state over APB.
// Assumes APB3 master on pclk, references asynchronous, one active selector.
// Contract
// - Lock to chosen reference, drive 10.24 MHz
// - Exactly one mode: tracking or free-run
// - Steer frequency, declare lock, keep trimming
// - On drift re-enter tracking, flash green
// - Unstable reference: track and flash, no error
// - Free-run by command or both lost (code: both lost gives holdover)
// - Flag reference out of specification
// - Auto-switch to other reference when good
// - Both bad: holdover, take first recovered
// - Track-primary: secondary fallback only if good
// - Primary preferred: revert when primary recovers
// - Track-secondary: primary fallback only if good
// - Secondary preferred: revert when secondary recovers
// - Time-out after auto switch blocks chatter
// - Line clock gives frame, multiframe counts
// - Enable references only when switched on
// - Use auxiliary pair or trunk pair, never mixed
`timescale 1ns/10ps
`include "rcs_defines.svh"
module rcs_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference inputs
  input wire logic trunk_ref_pri,
  input wire logic trunk_ref_sec,
  input wire logic aux_ref_pri,
  input wire logic aux_ref_sec,
  // Source enables and outputs
  output logic backplane_ref_line_one_en,
  output logic ref_sec_en,
  output logic sys_clk,
  output logic led_green,
  output logic led_red,
  output logic mf_start
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Phase step for 10.24 MHz from 20 MHz; the trim word adds a signed offset
  localparam logic [31:0] NCO_STEP = 32'(64'(`RCS_SYS_HZ) * 64'h100000000 / 64'(`RCS_PCLK_HZ));
  logic [3:0] ctrl_ff; // on, free, prefer secondary, aux group
  logic [3:0] nxt_ctrl;
  logic [23:0] tmo_ff; // Anti-chatter reload
  logic [23:0] nxt_tmo;
  rcs_pkg::rcs_state_t st_ff; // Controller state
  rcs_pkg::rcs_state_t nxt_st;
  logic use_sec_ff; // Active reference is secondary
  logic nxt_use_sec;
  logic [23:0] hold_ff; // Chatter guard countdown
  logic [23:0] nxt_hold;
  logic [15:0] win_ff; // Measurement window
  logic [15:0] nxt_win;
  logic [15:0] freq_ff; // Frequency trim word
  logic [15:0] nxt_freq;
  logic [15:0] locked_freq_ff; // Last trim word while locked
  logic [15:0] nxt_locked_freq;
  logic [31:0] phase_ff; // NCO phase
  logic [31:0] nxt_phase;
  logic [22:0] flash_ff; // Flash timebase
  logic [22:0] nxt_flash;
  logic sys_clk_ff;
  logic nxt_sys_clk;
  logic green_ff;
  logic nxt_green;
  logic red_ff;
  logic nxt_red;
  logic pri_en_ff;
  logic nxt_pri_en;
  logic sec_en_ff;
  logic nxt_sec_en;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic ready_ff;
  logic nxt_ready;
  logic err_ff;
  logic nxt_err;
  logic win_tick; // End of measurement window
  logic pri_in; // Group-selected pins
  logic sec_in;
  logic [15:0] pri_cnt;
  logic [15:0] sec_cnt;
  logic pri_ok;
  logic sec_ok;
  logic pri_edge;
  logic sec_edge;
  logic [15:0] ref_cnt;
  logic [15:0] exp_cnt;
  logic [15:0] diff;
  logic mf_pulse;
  logic [7:0] bit_pos_unused;
  logic [3:0] frame_pos_unused;
  logic apb_setup;
  // Register match, used by both the write and read decoders
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
    reg_hit = (a == off);
  endfunction
  // ****************************************************************
  // Reference group select
  // ****************************************************************
  // One group at a time, chosen by software as a whole
  assign pri_in = ctrl_ff[`RCS_CTL_AUX] ? aux_ref_pri : trunk_ref_pri;
  assign sec_in = ctrl_ff[`RCS_CTL_AUX] ? aux_ref_sec : trunk_ref_sec;
  assign win_tick = (win_ff == `RCS_WIN_CYC);
  // ****************************************************************
  // Monitors and frame counter
  // ****************************************************************
  // One monitor per reference; index 0 is the primary
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_mon
      logic [15:0] cnt_w;
      logic ok_w;
      logic edge_w;
      rcs_ref_mon u_mon (
        .pclk(pclk),
        .presetn(presetn),
        .ref_in(gi == 0 ? pri_in : sec_in),
        .win_tick(win_tick),
        .edge_cnt(cnt_w),
        .in_spec(ok_w),
        .ref_edge(edge_w)
      );
    end
  endgenerate
  assign pri_cnt = g_mon[0].cnt_w;
  assign sec_cnt = g_mon[1].cnt_w;
  assign pri_ok = g_mon[0].ok_w;
  assign sec_ok = g_mon[1].ok_w;
  assign pri_edge = g_mon[0].edge_w;
  assign sec_edge = g_mon[1].edge_w;
  // Frame count follows whichever reference is active
  rcs_frame_cnt u_frame (
    .pclk(pclk),
    .presetn(presetn),
    .bit_edge(use_sec_ff ? sec_edge : pri_edge),
    .bit_pos(bit_pos_unused),
    .frame_pos(frame_pos_unused),
    .mf_start(mf_pulse)
  );
  // ****************************************************************
  // Frequency comparison
  // ****************************************************************
  // Expected edges per window at the nominal line rate
  assign exp_cnt = 16'(`RCS_LINE_HZ / (`RCS_PCLK_HZ / 32'(`RCS_WIN_CYC)));
  assign ref_cnt = use_sec_ff ? sec_cnt : pri_cnt;
  assign diff = (ref_cnt > exp_cnt) ? ref_cnt - exp_cnt : exp_cnt - ref_cnt;
  // ****************************************************************
  // Controller next state
  // ****************************************************************
  // Selection, lock and holdover; the guard counter stops chatter
  always_comb begin
    logic act_ok;
    logic oth_ok;
    logic pref_sec;
    act_ok = use_sec_ff ? sec_ok : pri_ok;
    oth_ok = use_sec_ff ? pri_ok : sec_ok;
    pref_sec = ctrl_ff[`RCS_CTL_PREF];
    nxt_st = st_ff;
    nxt_use_sec = use_sec_ff;
    nxt_hold = (hold_ff != 24'h000000) ? hold_ff - 24'h000001 : hold_ff;
    nxt_win = win_tick ? 16'h0000 : win_ff + 16'h0001;
    nxt_freq = freq_ff;
    nxt_locked_freq = locked_freq_ff;
    unique case (st_ff)
      rcs_pkg::RCS_ST_FREE: begin
        // Ignores references; leaves only by command with a good source
        nxt_freq = `RCS_FREQ_MID;
        if (ctrl_ff[`RCS_CTL_ON] && !ctrl_ff[`RCS_CTL_FREE] && (pri_ok || sec_ok)) begin
          nxt_st = rcs_pkg::RCS_ST_TRACK;
          nxt_use_sec = pref_sec ? sec_ok : !pri_ok;
        end
      end
      rcs_pkg::RCS_ST_TRACK, rcs_pkg::RCS_ST_LOCK: begin
        if (win_tick) begin
          // Coarse steps while tracking, single steps once locked
          if (ref_cnt > exp_cnt) begin
            nxt_freq = freq_ff + ((st_ff == rcs_pkg::RCS_ST_LOCK) ? 16'h0001 : 16'h0010);
          end else if (ref_cnt < exp_cnt) begin
            nxt_freq = freq_ff - ((st_ff == rcs_pkg::RCS_ST_LOCK) ? 16'h0001 : 16'h0010);
          end
          // Drift drops back to tracking; jitter keeps it there, not an error
          nxt_st = (diff <= `RCS_LOCK_TOL) ? rcs_pkg::RCS_ST_LOCK : rcs_pkg::RCS_ST_TRACK;
        end
        if (st_ff == rcs_pkg::RCS_ST_LOCK) begin
          nxt_locked_freq = freq_ff;
        end
        if (!act_ok && oth_ok && hold_ff == 24'h000000) begin
          // Fall over only to a good reference, then guard
          nxt_use_sec = !use_sec_ff;
          nxt_st = rcs_pkg::RCS_ST_TRACK;
          nxt_hold = tmo_ff;
        end else if (!act_ok && !oth_ok) begin
          nxt_st = rcs_pkg::RCS_ST_HOLD;
        end else if (act_ok && (use_sec_ff != pref_sec) && (pref_sec ? sec_ok : pri_ok)
                     && hold_ff == 24'h000000) begin
          // Preferred reference back: revert to it
          nxt_use_sec = pref_sec;
          nxt_st = rcs_pkg::RCS_ST_TRACK;
          nxt_hold = tmo_ff;
        end
      end
      rcs_pkg::RCS_ST_HOLD: begin
        // Frozen word; first reference to recover wins
        nxt_freq = locked_freq_ff;
        if (pri_ok || sec_ok) begin
          nxt_use_sec = !pri_ok;
          nxt_st = rcs_pkg::RCS_ST_TRACK;
        end
      end
      default: begin
        nxt_st = rcs_pkg::RCS_ST_FREE;
      end
    endcase
    // Command or loss of controller power forces free-run
    if (!ctrl_ff[`RCS_CTL_ON] || ctrl_ff[`RCS_CTL_FREE]) begin
      nxt_st = rcs_pkg::RCS_ST_FREE;
    end
  end
  // ****************************************************************
  // System clock and indicators
  // ****************************************************************
  // NCO at 10.24 MHz nominal; trim word offsets the step
  always_comb begin
    nxt_phase = phase_ff + NCO_STEP + 32'({{16{freq_ff[15] ^ 1'b1}}, freq_ff ^ 16'h8000});
    nxt_sys_clk = phase_ff[31];
    nxt_flash = flash_ff + 23'h000001;
    nxt_red = 1'b0;
    nxt_green = 1'b0;
    if (ctrl_ff[`RCS_CTL_ON]) begin
      // Green flashes while tracking, red marks holdover
      unique case (st_ff)
        rcs_pkg::RCS_ST_TRACK: nxt_green = flash_ff[`RCS_FLASH_BIT];
        rcs_pkg::RCS_ST_HOLD: nxt_red = 1'b1;
        default: nxt_green = 1'b1;
      endcase
    end
    // Sources driven only while this controller is switched on
    nxt_pri_en = ctrl_ff[`RCS_CTL_ON] && !use_sec_ff;
    nxt_sec_en = ctrl_ff[`RCS_CTL_ON] && use_sec_ff;
  end
  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Zero wait states; unmapped addresses answer pslverr
  assign apb_setup = psel && !penable;
  // Reads sample state at the setup edge; writes land at the access edge
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_tmo = tmo_ff;
    nxt_rdata = rdata_ff;
    nxt_ready = apb_setup;
    nxt_err = 1'b0;
    if (apb_setup) begin
      nxt_err = !(reg_hit(paddr, `RCS_OFF_CTRL) || reg_hit(paddr, `RCS_OFF_STAT)
                  || reg_hit(paddr, `RCS_OFF_TMO) || reg_hit(paddr, `RCS_OFF_FREQ));
      nxt_rdata = 32'h00000000;
      if (!pwrite) begin
        if (reg_hit(paddr, `RCS_OFF_CTRL)) nxt_rdata = {28'h0000000, ctrl_ff};
        if (reg_hit(paddr, `RCS_OFF_STAT)) nxt_rdata = {24'h000000, pri_ok, sec_ok,
                                                         use_sec_ff, hold_ff != 24'h000000, st_ff};
        if (reg_hit(paddr, `RCS_OFF_TMO)) nxt_rdata = {8'h00, tmo_ff};
        if (reg_hit(paddr, `RCS_OFF_FREQ)) nxt_rdata = {16'h0000, freq_ff};
      end
    end
    if (psel && penable && ready_ff && pwrite) begin
      if (reg_hit(paddr, `RCS_OFF_CTRL)) nxt_ctrl = pwdata[3:0];
      if (reg_hit(paddr, `RCS_OFF_TMO)) nxt_tmo = pwdata[23:0];
    end
  end
  // ****************************************************************
  // Registers
  // ****************************************************************
  // All state resets to free-run with the controller off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `RCS_CTL_RST;
      tmo_ff <= `RCS_TMO_RST;
      st_ff <= rcs_pkg::RCS_ST_FREE;
      use_sec_ff <= 1'b0;
      hold_ff <= 24'h000000;
      win_ff <= 16'h0000;
      freq_ff <= `RCS_FREQ_MID;
      locked_freq_ff <= `RCS_FREQ_MID;
      phase_ff <= 32'h00000000;
      flash_ff <= 23'h000000;
      sys_clk_ff <= 1'b0;
      green_ff <= 1'b0;
      red_ff <= 1'b0;
      pri_en_ff <= 1'b0;
      sec_en_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      tmo_ff <= nxt_tmo;
      st_ff <= nxt_st;
      use_sec_ff <= nxt_use_sec;
      hold_ff <= nxt_hold;
      win_ff <= nxt_win;
      freq_ff <= nxt_freq;
      locked_freq_ff <= nxt_locked_freq;
      phase_ff <= nxt_phase;
      flash_ff <= nxt_flash;
      sys_clk_ff <= nxt_sys_clk;
      green_ff <= nxt_green;
      red_ff <= nxt_red;
      pri_en_ff <= nxt_pri_en;
      sec_en_ff <= nxt_sec_en;
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
    end
  end
  // Every output is a flip-flop; these assigns only rename
  assign prdata = rdata_ff;
  assign pready = ready_ff;
  assign pslverr = err_ff;
  assign backplane_ref_line_one_en = pri_en_ff;
  assign ref_sec_en = sec_en_ff;
  assign sys_clk = sys_clk_ff;
  assign led_green = green_ff;
  assign led_red = red_ff;
  assign mf_start = mf_pulse;
endmodule // rcs_top

/* File: test/rcs_top_props.sv */
// Checker for the selector's ports: APB handshake, source enables, LEDs, clocks.
// Assumes it is bound to rcs_top and sees only that module's ports.
`timescale 1ns/10ps
`include "rcs_defines.svh"
module rcs_top_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic backplane_ref_line_one_en,
  input wire logic ref_sec_en,
  input wire logic sys_clk,
  input wire logic led_green,
  input wire logic led_red,
  input wire logic mf_start
);
  logic [3:0] ctl_ff;  // Shadow of the control word
  logic [3:0] nxt_ctl;
  logic [2:0] age_ff;  // Cycles since the last control write, stops at 7
  logic [2:0] nxt_age;
  logic wr_ctl;  // A control write lands at this edge
  // ********
  // Helper logic
  // ********
  assign wr_ctl = psel && penable && pready && pwrite && (paddr == `RCS_OFF_CTRL);
  // Outputs are registered, so pins get seven cycles to settle after a write
  always_comb begin
    nxt_ctl = wr_ctl ? pwdata[3:0] : ctl_ff;
    nxt_age = wr_ctl ? 3'h0 : ((age_ff == 3'h7) ? 3'h7 : age_ff + 3'h1);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= 4'h0;
      age_ff <= 3'h7;
    end else begin
      ctl_ff <= nxt_ctl;
      age_ff <= nxt_age;
    end
  end
  // ********
  // Assertions
  // ********
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_next: assert property (s_setup |=> s_access)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready |->
    (pslverr == ((paddr > `RCS_OFF_FREQ) || (paddr[1:0] != 2'h0))))
    else $error("error flag wrong for address");
  a_ctl_readback: assert property (s_access ##0 (!pwrite && paddr == `RCS_OFF_CTRL)
    |-> prdata[3:0] == ctl_ff) else $error("control readback differs");
  a_off_dark: assert property ((age_ff == 3'h7) && !ctl_ff[0] |->
    !backplane_ref_line_one_en && !ref_sec_en && !led_green && !led_red)
    else $error("outputs active while off");
  a_free_green: assert property ((age_ff == 3'h7) && ctl_ff[0] && ctl_ff[1] |->
    led_green && !led_red && (backplane_ref_line_one_en != ref_sec_en))
    else $error("free-run pins wrong");
  a_one_source: assert property (!(backplane_ref_line_one_en && ref_sec_en))
    else $error("both sources enabled");
  a_mf_pulse: assert property (mf_start |=> !mf_start [*8])
    else $error("multiframe pulse too close");
  a_sysclk_low: assert property (!sys_clk [*4] |=> sys_clk)
    else $error("system clock stuck low");
  a_sysclk_high: assert property (sys_clk [*4] |=> !sys_clk)
    else $error("system clock stuck high");
endmodule // rcs_top_props

bind rcs_top rcs_top_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .backplane_ref_line_one_en, .ref_sec_en, .sys_clk,
  .led_green, .led_red, .mf_start);

/* File: test/rcs_ref_src.sv */
// Model of one trunk card or auxiliary source giving a recovered line clock.
// Assumes the bench sets mode: 0 lost, 1 nominal 2.0 MHz, 2 off frequency.
`timescale 1ns/10ps
module rcs_ref_src #(
  parameter real PHASE_NS = 0.0  // Start offset, keeps sources unrelated
) (
  // Control from the bench
  input wire logic [1:0] mode,
  // Recovered clock
  output logic ref_out
);
  // ********
  // Source
  // ********
  // A lost line reads low: the line receiver fails safe, no stale level survives
  initial begin
    ref_out = 1'b0;
    #(PHASE_NS);
    forever begin
      case (mode)
        2'h1: #250.0 ref_out = !ref_out;  // Nominal
        2'h2: #275.0 ref_out = !ref_out;  // Ten percent slow
        default: #250.0 ref_out = 1'b0;  // Source lost
      endcase
    end
  end
endmodule // rcs_ref_src

/* File: test/tb.sv */
// Bench for the selector: APB reads queued and checked by a monitor.
// Assumes four modelled sources and a 20 MHz pclk.
`timescale 1ns/10ps
`include "rcs_defines.svh"
module tb;
  // ********
  // Signals
  // ********
  typedef struct packed {logic chk; logic err; logic [31:0] msk; logic [31:0] val;} rcs_exp_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, tmo, seed_v;
  logic tp, ts, ap, as_r, bp_en, sec_en, sys_clk, led_g, led_r, mf;
  logic [1:0] m_tp, m_ts, m_ap, m_as;  // Source modes
  rcs_exp_t exp_q[$];  // Expected read results, oldest first
  rcs_exp_t mon_e;
  int fail_count = 0;
  int cmp_count = 0;
  rcs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trunk_ref_pri(tp), .trunk_ref_sec(ts), .aux_ref_pri(ap),
    .aux_ref_sec(as_r), .backplane_ref_line_one_en(bp_en), .ref_sec_en(sec_en),
    .sys_clk(sys_clk), .led_green(led_g), .led_red(led_r), .mf_start(mf));
  rcs_ref_src #(.PHASE_NS(3.0)) u_tp (.mode(m_tp), .ref_out(tp));
  rcs_ref_src #(.PHASE_NS(71.0)) u_ts (.mode(m_ts), .ref_out(ts));
  rcs_ref_src #(.PHASE_NS(137.0)) u_ap (.mode(m_ap), .ref_out(ap));
  rcs_ref_src #(.PHASE_NS(199.0)) u_as (.mode(m_as), .ref_out(as_r));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ********
  // Tasks
  // ********
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until ready is seen at an edge, then releases
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v,
                        input logic e, input logic c);
    exp_q.push_back('{c, e, m, v});
    apb(1'b0, a, 32'h0);
  endtask
  // Status polls are unchecked; only the last read is compared
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    rd_chk(`RCS_OFF_STAT, m, v, 1'b0, 1'b0);
    while (((rd & m) !== v) && (n < 1500)) begin
      repeat (16) @(posedge pclk);
      rd_chk(`RCS_OFF_STAT, m, v, 1'b0, 1'b0);
      n++;
    end
    rd_chk(`RCS_OFF_STAT, m, v, 1'b0, 1'b1);
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
    if ((fail_count == 0) && (cmp_count > 0)) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Monitor: each completed read takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && (pready === 1'b1) && !pwrite && (exp_q.size() > 0)) begin
      mon_e = exp_q.pop_front();
      if (mon_e.chk) begin
        cmp_word(prdata & mon_e.msk, mon_e.val);
        cmp_word({31'h0, pslverr}, {31'h0, mon_e.err});
      end
    end
  end
  // Watchdog sized above the longest expected run
  initial begin
    repeat (95000) @(posedge pclk);
    fail_count++;
    summarize();
  end
  // ********
  // Tests
  // ********
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    {m_tp, m_ts, m_ap, m_as} = 8'h55;
    seed_v = $urandom(32'h43049aef);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`RCS_OFF_CTRL, 32'hffffffff, 32'h0, 1'b0, 1'b1);
    rd_chk(`RCS_OFF_TMO, 32'h00ffffff, {8'h0, `RCS_TMO_RST}, 1'b0, 1'b1);
    rd_chk(`RCS_OFF_FREQ, 32'h0000ffff, {16'h0, `RCS_FREQ_MID}, 1'b0, 1'b1);
    apb(1'b1, `RCS_OFF_STAT, 32'hffffffff);
    rd_chk(`RCS_OFF_STAT, 32'h0000000f, 32'h1, 1'b0, 1'b1);
    apb(1'b1, 12'h010, $urandom);
    rd_chk(12'h010, 32'hffffffff, 32'h0, 1'b1, 1'b1);
    rd_chk(`RCS_OFF_CTRL, 32'hffffffff, 32'h0, 1'b0, 1'b1);
    $display("done: reset and map");
    tmo = 32'h40 + ($urandom % 32'h20);
    apb(1'b1, `RCS_OFF_TMO, tmo);
    rd_chk(`RCS_OFF_TMO, 32'h00ffffff, tmo, 1'b0, 1'b1);
    apb(1'b1, `RCS_OFF_CTRL, 32'h1);
    poll(32'h2f, 32'h04);
    rd_chk(`RCS_OFF_STAT, 32'hc0, 32'hc0, 1'b0, 1'b1);
    @(negedge pclk);
    cmp_word({30'h0, led_g, bp_en}, 32'h3);
    $display("done: lock to primary");
    m_tp = 2'h2;
    poll(32'ha0, 32'h20);
    m_ts = 2'h0;
    poll(32'h0f, 32'h08);
    rd_chk(`RCS_OFF_STAT, 32'hc0, 32'h0, 1'b0, 1'b1);
    @(negedge pclk);
    cmp_word({31'h0, led_r}, 32'h1);
    $display("done: switch and holdover");
    m_ts = 2'h1;
    poll(32'h68, 32'h60);
    m_tp = 2'h1;
    poll(32'hb0, 32'h90);
    poll(32'h10, 32'h00);
    $display("done: recovery and revert");
    apb(1'b1, `RCS_OFF_CTRL, 32'h5);
    poll(32'h20, 32'h20);
    m_ts = 2'h0;
    poll(32'h20, 32'h00);
    m_ts = 2'h1;
    $display("done: secondary preferred");
    m_ap = 2'h0;
    m_as = 2'h0;
    apb(1'b1, `RCS_OFF_CTRL, 32'h9);
    poll(32'hc0, 32'h00);
    $display("done: auxiliary group");
    apb(1'b1, `RCS_OFF_CTRL, 32'h3);
    poll(32'h0f, 32'h01);
    @(negedge pclk);
    cmp_word({30'h0, led_g, led_r}, 32'h2);
    apb(1'b1, `RCS_OFF_CTRL, 32'h0);
    rd_chk(`RCS_OFF_STAT, 32'h0f, 32'h01, 1'b0, 1'b1);
    @(negedge pclk);
    cmp_word({28'h0, bp_en, sec_en, led_g, led_r}, 32'h0);
    $display("done: free-run and off");
    summarize();
  end
endmodule // tb
